// ---- common/pmc_pkg.sv ----
package pmc_pkg;

	// ------------------------------------------------------------
	// sizes and field positions
	// ------------------------------------------------------------
	localparam int NUM_COUNTERS     = 8;
	localparam int COUNTER_WIDTH    = 46;
	localparam int EVENT_WIDTH      = 2;
	localparam int NUM_GROUPS       = 4;
	localparam int GROUP_WIDTH      = 2;
	localparam int POINTER_WIDTH    = 4;
	localparam int SCALAR_WIDTH     = 64;
	localparam int LOW_SLICE_LSB    = 0;
	localparam int LOW_SLICE_MSB    = 25;
	localparam int HIGH_SLICE_LSB   = 26;
	localparam int HIGH_SLICE_MSB   = 45;
	localparam int LOW_DEST_LSB     = 32;
	localparam int HIGH_DEST_LSB    = 38;
	localparam int DEST_MSB         = 57;
	localparam int TEST_LOW_BIT_A   = 0;
	localparam int TEST_LOW_BIT_B   = 6;
	localparam int TEST_HIGH_BIT    = 26;
	localparam int MAX_STEP         = 3;

	// ------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------
	localparam logic [POINTER_WIDTH-1:0] POINTER_RESET = 4'h0;
	localparam logic [GROUP_WIDTH-1:0]   GROUP_RESET   = 2'h0;
	localparam logic [COUNTER_WIDTH-1:0] COUNTER_RESET = 46'h0000_0000_0000;

	// ------------------------------------------------------------
	// instruction strobes and read answer
	// ------------------------------------------------------------
	typedef struct packed {
		logic                   select_event_group_instruction;
		logic [GROUP_WIDTH-1:0] group_operand;
		logic                   read_counter_slice_instruction;
		logic                   test_increment_instruction;
	} pmc_cmd_s;

	typedef struct packed {
		logic                    valid;
		logic [SCALAR_WIDTH-1:0] data;
	} pmc_result_s;

	// per-counter event counts for one group, 0..3 each
	typedef logic [NUM_COUNTERS-1:0][EVENT_WIDTH-1:0] pmc_events_t;

endpackage

// ---- dv/pmc_asserts.sv ----
`timescale 1ns/1ps
// port-level checks of the counter block
module pmc_asserts (
	input wire logic	clock,
	input wire logic	rst,
	input wire logic	clock_en,
	input wire logic	monitor_mode,
	input wire pmc_pkg::pmc_cmd_s	cmd,
	input wire pmc_pkg::pmc_result_s	result,
	input wire logic [1:0]	group_sel,
	input wire logic [3:0]	slice_pointer
);
	import pmc_pkg::*;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// strobes the block really takes; a frozen edge takes nothing
	wire rd = clock_en && cmd.read_counter_slice_instruction;
	wire ts = clock_en && cmd.test_increment_instruction;
	// monitor mode held across the edge, so no entry zeroing
	sequence s_hold;
		monitor_mode && $past(monitor_mode) && $past(clock_en) && !$past(rst);
	endsequence
	property p_sel;
		clock_en && cmd.select_event_group_instruction |=> group_sel == $past(cmd.group_operand);
	endproperty
	a_sel: assert property (p_sel) else $error("bad group");
	property p_adv;
		rd ##0 s_hold |=> slice_pointer == $past(slice_pointer) + 4'h1;
	endproperty
	a_adv: assert property (p_adv) else $error("bad pointer step");
	property p_entry;
		clock_en && $past(clock_en) && $rose(monitor_mode) |=> slice_pointer == 4'h0;
	endproperty
	a_entry: assert property (p_entry) else $error("pointer not cleared");
	property p_tsp;
		ts && !rd ##0 s_hold |=> $stable(slice_pointer);
	endproperty
	a_tsp: assert property (p_tsp) else $error("pointer moved");
	property p_ones;
		ts |=> result.valid && (&result.data);
	endproperty
	a_ones: assert property (p_ones) else $error("no all ones");
	property p_rd;
		rd ##1 clock_en |=> result.valid;
	endproperty
	a_rd: assert property (p_rd) else $error("no read answer");
	property p_lo;
		rd && !slice_pointer[0] ##1 clock_en |=> result.data[31:0] == '0 && result.data[63:58] == '0;
	endproperty
	a_lo: assert property (p_lo) else $error("bad low slice");
	property p_hi;
		rd && slice_pointer[0] ##1 clock_en |=> result.data[37:0] == '0;
	endproperty
	a_hi: assert property (p_hi) else $error("bad high slice");
endmodule
bind pmc_perf_counters pmc_asserts i_chk (.clock(clock), .rst(rst), .clock_en(clock_en),
	.monitor_mode(monitor_mode), .cmd(cmd), .result(result), .group_sel(group_sel),
	.slice_pointer(slice_pointer));

// ---- dv/pmc_cpu_model.sv ----
`timescale 1ns/1ps
// issue logic and event sources seen from the counter block
module pmc_cpu_model (
	input wire logic		clock,
	output logic			monitor_mode,
	output pmc_pkg::pmc_events_t	ev [4],
	output pmc_pkg::pmc_cmd_s	cmd
);
	import pmc_pkg::*;
	// power up in monitor mode with nothing issued
	initial begin
		monitor_mode = 1'b1;
		cmd = '0;
		ev = '{default: '0};
	end
	// fresh counts every period, two bits each so never above three
	always @(posedge clock) begin
		for (int g = 0; g < 4; g++) begin
			ev[g] <= pmc_events_t'($urandom);
		end
	end
	// one-period pulse; calls in a row keep the minimum spacing
	task automatic op(input int k, input logic [1:0] a);
		@(posedge clock);
		cmd <= pmc_cmd_s'({k == 0, a, k == 1, k == 2});
		@(posedge clock);
		cmd <= '0;
	endtask
	// mode change, then one quiet period
	task automatic mode(input logic m);
		@(posedge clock);
		monitor_mode <= m;
		@(posedge clock);
	endtask
endmodule

// ---- dv/pmc_perf_counters_tb_top.sv ----
`timescale 1ns/1ps
module pmc_perf_counters_tb_top;
	import pmc_pkg::*;
	logic		clock = 1'b0;
	logic		rst = 1'b1;
	logic		ce = 1'b1;
	logic		mon, prev_m;
	pmc_events_t	ev [4];
	pmc_cmd_s	cmd;
	pmc_result_s	result, want, e1;
	logic [1:0]	grp_o, grp;
	logic [3:0]	ptr_o, ptr;
	logic [45:0]	cnt [8];
	int		err_count = 0;
	int		comparisons = 0;
	// free-running clock
	initial begin
		forever #5 clock = ~clock;
	end
	pmc_cpu_model i_cpu (.clock(clock), .monitor_mode(mon), .ev(ev), .cmd(cmd));
	pmc_perf_counters i_dut (.clock(clock), .rst(rst), .clock_en(ce), .monitor_mode(mon),
		.group0_events(ev[0]), .group1_events(ev[1]), .group2_events(ev[2]),
		.group3_events(ev[3]), .cmd(cmd), .result(result), .group_sel(grp_o),
		.slice_pointer(ptr_o));
	// destination word for one slice
	function automatic logic [63:0] slice(input logic [45:0] c, input logic hi);
		return hi ? {6'h0, c[45:26], 38'h0} : {6'h0, c[25:0], 32'h0};
	endfunction
	task automatic chk(input logic [64:0] got, input logic [64:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// reference model on the values in force before each edge
	always @(posedge clock) begin
		if (rst) begin
			cnt = '{default: '0};
			{ptr, grp, prev_m, want, e1} = '0;
		end else begin
			chk(result, want);
			chk(65'(ptr_o), 65'(ptr));
			chk(65'(grp_o), 65'(grp));
			if (ce) begin
				want = cmd.test_increment_instruction ? 65'h1_ffff_ffff_ffff_ffff : e1;
				e1 = cmd.read_counter_slice_instruction ? {1'h1, slice(cnt[ptr[3:1]], ptr[0])} : '0;
				if (mon && cmd.test_increment_instruction)
					cnt[ptr[3:1]] += ptr[0] ? 46'h0000_0400_0000 : 46'h0000_0000_0041;
				for (int i = 0; i < 8; i++) begin
					if (!mon) cnt[i] += 46'(ev[grp][i]);
				end
				ptr = (mon && !prev_m) ? 4'h0 : ptr + 4'(cmd.read_counter_slice_instruction);
				prev_m = mon;
				if (cmd.select_event_group_instruction) begin
					cnt = '{default: '0};
					grp = cmd.group_operand;
				end
			end
		end
	end
	// each group: count with stalls, then test and read back in monitor mode
	initial begin
		void'($urandom(32'hde0e_9b3d));
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		i_cpu.op(0, 2'h0);
		for (int g = 0; g < 4; g++) begin
			i_cpu.mode(1'b0);
			i_cpu.op(2, 2'h0);
			repeat (40) begin
				@(posedge clock);
				ce <= ($urandom % 5) != 0;
			end
			@(posedge clock);
			ce <= 1'b1;
			i_cpu.mode(1'b1);
			i_cpu.op(2, 2'h0);
			i_cpu.op(2, 2'h0);
			i_cpu.op(1, 2'h0);
			i_cpu.op(2, 2'h0);
			repeat (17) i_cpu.op(1, 2'h0);
			i_cpu.op(0, 2'(g + 1));
		end
		// let the last answer and group change reach the checks
		repeat (4) @(posedge clock);
		conclude();
	end
endmodule

// ---- rtl/pmc_counter_bank.sv ----
`timescale 1ns/1ps

// small memory of counters, read data from a register
module pmc_counter_bank #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 46
) (
	// clock and reset
	input  wire logic                     clock,
	input  wire logic                     rst,
	input  wire logic                     clock_en,
	// per-entry next values
	input  wire logic [DEPTH-1:0]         write_en,
	input  wire logic [DEPTH-1:0][WIDTH-1:0] write_data,
	// registered read port
	input  wire logic [$clog2(DEPTH)-1:0] read_addr,
	output logic      [WIDTH-1:0]         read_data,
	// whole array for the counting adders
	output logic      [DEPTH-1:0][WIDTH-1:0] entries
);
	import pmc_pkg::*;

	logic [DEPTH-1:0][WIDTH-1:0] mem_reg;
	logic [DEPTH-1:0][WIDTH-1:0] mem_next;
	logic [WIDTH-1:0]            read_reg;
	logic [WIDTH-1:0]            read_next;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		mem_next  = mem_reg;
		read_next = mem_reg[read_addr];
		for (int i = 0; i < DEPTH; i++) begin
			if (write_en[i]) begin
				mem_next[i] = write_data[i];
			end
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			mem_reg  <= '0;
			read_reg <= '0;
		end else if (clock_en) begin
			mem_reg  <= mem_next;
			read_reg <= read_next;
		end
	end

	assign read_data = read_reg;
	assign entries   = mem_reg;
endmodule

// ---- rtl/pmc_perf_counters.sv ----
`timescale 1ns/1ps

// What this block does
// R01: user mode adds 0..3 events per period
// R02: count only in user mode
// R03: group select picks group, clears counters
// R04: instructions issued only in monitor mode; the block takes them in either mode, only the test add needs monitor mode
// R05: groups zero and one event map
// R06: groups two and three event map
// R07: read copies one slice to destination
// R08: monitor entry zeroes slice pointer
// R09: each read advances pointer by one; a read on the monitor-entry edge leaves the pointer at zero
// R10: even pointer low slice, counter pointer/2
// R11: low slice bits 0-25 to 32-57
// R12: high slice bits 26-45 to 38-57
// R13: two periods between reads
// R14: test increment bits 0,6 or 26
// R15: test increment leaves pointer alone
// R16: one period between test increments
// R17: test increment writes all ones; a read answer due on the same edge puts its slice field in place of the ones
// R18: counters and pointer wrap
module pmc_perf_counters #(
	parameter int NUM_CNT = pmc_pkg::NUM_COUNTERS,
	parameter int CNT_W   = pmc_pkg::COUNTER_WIDTH
) (
	// clock, reset, enable
	input  wire logic                clock,
	input  wire logic                rst,
	input  wire logic                clock_en,
	// processor mode
	input  wire logic                monitor_mode,
	// event sources, one count per group and counter
	input  wire pmc_pkg::pmc_events_t group0_events,
	input  wire pmc_pkg::pmc_events_t group1_events,
	input  wire pmc_pkg::pmc_events_t group2_events,
	input  wire pmc_pkg::pmc_events_t group3_events,
	// instruction strobes
	input  wire pmc_pkg::pmc_cmd_s    cmd,
	// scalar destination write
	output pmc_pkg::pmc_result_s      result,
	// visible state
	output logic [pmc_pkg::GROUP_WIDTH-1:0]   group_sel,
	output logic [pmc_pkg::POINTER_WIDTH-1:0] slice_pointer
);
	import pmc_pkg::*;

	// width of a counter index
	localparam int ADDR_W = $clog2(NUM_CNT);

	typedef enum logic [1:0] {
		PMC_IDLE = 2'b01,
		PMC_READ = 2'b10
	} pmc_state_e;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	pmc_state_e                 state_reg, state_next;
	logic [GROUP_WIDTH-1:0]     group_reg, group_next;
	logic [POINTER_WIDTH-1:0]   ptr_reg, ptr_next;
	logic                       mon_reg, mon_next;
	logic                       odd_reg, odd_next;
	pmc_result_s                res_reg, res_next;
	pmc_events_t                sel_events;
	logic [NUM_CNT-1:0]         wr_en;
	logic [NUM_CNT-1:0][CNT_W-1:0] wr_data;
	logic [NUM_CNT-1:0][CNT_W-1:0] cnt;
	logic [CNT_W-1:0]           rd_data;
	logic [CNT_W-1:0]           test_mask;
	logic [$clog2(NUM_CNT)-1:0] rd_addr;
	logic                       monitor_entry;

	// counter memory, read slot registered for the answer
	// the slot loads every enabled edge; only the read machine looks at it
	pmc_counter_bank #(
		.DEPTH(NUM_CNT),
		.WIDTH(CNT_W)
	) u_bank (
		.clock     (clock),
		.rst       (rst),
		.clock_en  (clock_en),
		.write_en  (wr_en),
		.write_data(wr_data),
		.read_addr (rd_addr),
		.read_data (rd_data),
		.entries   (cnt)
	);

	// ------------------------------------------------------------
	// event group mux
	// ------------------------------------------------------------
	// the event wiring per group lives in the sources; here only selection
	// group only changes with a select, which clears the counts as well
	always_comb begin
		unique case (group_reg)
			2'h0:    sel_events = group0_events; // R05
			2'h1:    sel_events = group1_events; // R05
			2'h2:    sel_events = group2_events; // R06
			default: sel_events = group3_events; // R06
		endcase
	end

	// counter addressed by pointer / 2
	assign rd_addr = ptr_reg[POINTER_WIDTH-1:1]; // R10

	// ------------------------------------------------------------
	// monitor entry
	// ------------------------------------------------------------
	// level high now, last enabled sample low; the sample flop resets
	// low, so monitor mode held through reset also parks the pointer
	assign monitor_entry = monitor_mode && !mon_reg; // R08

	// test pattern: even pointer bits 0 and 6, odd pointer bit 26
	// the mask depends on the pointer only; it is added only on a test strobe
	always_comb begin
		test_mask = '0;
		if (ptr_reg[0]) begin
			test_mask[TEST_HIGH_BIT] = 1'b1; // R14
		end else begin
			test_mask[TEST_LOW_BIT_A] = 1'b1; // R14
			test_mask[TEST_LOW_BIT_B] = 1'b1; // R14
		end
	end

	// ------------------------------------------------------------
	// counter updates, one per entry
	// ------------------------------------------------------------
	// the test add is a plain add of the mask, so carries ripple like a count
	// priority: select clears, then the monitor-mode test add, then user-mode
	// counting; the two adds never meet since the mode splits them
	for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
		always_comb begin
			wr_en[i]   = 1'b0;
			wr_data[i] = cnt[i];
			if (cmd.select_event_group_instruction) begin
				wr_en[i]   = 1'b1;
				wr_data[i] = COUNTER_RESET; // R03
			end else if (cmd.test_increment_instruction && monitor_mode
					&& rd_addr == ADDR_W'(i)) begin
				wr_en[i]   = 1'b1;
				wr_data[i] = cnt[i] + test_mask; // R14 R18
			end else if (!monitor_mode) begin
				// events never exceed 3 since each count is two bits
				wr_en[i]   = 1'b1; // R02
				wr_data[i] = cnt[i] + CNT_W'(sel_events[i]); // R01 R18
			end
		end
	end

	// ------------------------------------------------------------
	// control and answer next state
	// ------------------------------------------------------------
	// the answer register clears on every enabled edge, so result stands
	// until the next enabled edge and reads zero between answers
	always_comb begin
		state_next = state_reg;
		group_next = group_reg;
		ptr_next   = ptr_reg;
		mon_next   = monitor_mode;
		odd_next   = odd_reg;
		res_next   = '0;
		if (cmd.select_event_group_instruction) begin
			group_next = cmd.group_operand; // R03
		end
		// a test increment is not in this chain, so it never moves the pointer
		if (monitor_entry) begin
			ptr_next = POINTER_RESET; // R08
		end else if (cmd.read_counter_slice_instruction) begin
			ptr_next = ptr_reg + 4'h1; // R09 R18
		end // R15
		if (cmd.test_increment_instruction) begin
			res_next.valid = 1'b1;
			res_next.data  = '1; // R17
		end
		// a read answers one edge after it is taken: the bank slot loads on
		// the taken edge, the answer register on the next one; a second read
		// inside that window finds the machine busy and is lost
		unique case (state_reg)
			PMC_IDLE: begin
				if (cmd.read_counter_slice_instruction) begin
					odd_next   = ptr_reg[0]; // R10
					state_next = PMC_READ;
				end
			end
			PMC_READ: begin
				// bank read register now holds the chosen counter
				// a test answer due on this edge keeps its ones outside the slice field, which takes the read data
				res_next.valid = 1'b1;
				if (odd_reg) begin
					res_next.data[DEST_MSB:HIGH_DEST_LSB] =
						rd_data[HIGH_SLICE_MSB:HIGH_SLICE_LSB]; // R12
				end else begin
					res_next.data[DEST_MSB:LOW_DEST_LSB] =
						rd_data[LOW_SLICE_MSB:LOW_SLICE_LSB]; // R11
				end // R07
				state_next = PMC_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// reset acts on any edge; a low clock enable holds every flop
	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= PMC_IDLE;
			group_reg <= GROUP_RESET;
			ptr_reg   <= POINTER_RESET;
			mon_reg   <= 1'b0;
			odd_reg   <= 1'b0;
			res_reg   <= '0;
		end else if (clock_en) begin
			state_reg <= state_next;
			group_reg <= group_next;
			ptr_reg   <= ptr_next;
			mon_reg   <= mon_next;
			odd_reg   <= odd_next;
			res_reg   <= res_next;
		end
	end

	// outputs come straight from flops
	assign result        = res_reg;
	assign group_sel     = group_reg;
	assign slice_pointer = ptr_reg;
endmodule
